/* shared/atp_pkg.sv */
package atp_pkg;

    // ****************************************
    // counter limits and control layout
    // ****************************************
    localparam logic [7:0] CNT_MAX     = 8'hff;
    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_ONE     = 8'h01;
    localparam int         CTL_FORCE   = 7;
    localparam int         CTL_WGM0    = 6;
    localparam int         CTL_COM_LSB = 4;
    localparam int         CTL_WGM1    = 3;
    localparam int         CTL_CS_LSB  = 0;

    // ****************************************
    // encodings and transfer timing
    // ****************************************
    typedef enum logic [1:0] {WGM_NORMAL, WGM_PHASE, WGM_CTC, WGM_FAST} atp_wgm_e;
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_CLR_UP = 2'h2;
    localparam logic [1:0] COM_SET_UP = 2'h3;
    localparam int         CH_CNT     = 0;
    localparam int         CH_OCR     = 1;
    localparam int         CH_CTL     = 2;
    localparam logic [1:0] XFER_EDGES = 2'h2;

    // prescaler tap mask per clock select code
    function automatic logic [9:0] presc_mask(input logic [2:0] sel);
        case (sel)
            3'h2:    presc_mask = 10'h007;
            3'h3:    presc_mask = 10'h01f;
            3'h4:    presc_mask = 10'h03f;
            3'h5:    presc_mask = 10'h07f;
            3'h6:    presc_mask = 10'h0ff;
            3'h7:    presc_mask = 10'h3ff;
            default: presc_mask = 10'h000;
        endcase
    endfunction

    // ****************************************
    // core state and its reset value
    // ****************************************
    typedef struct packed {
        logic [2:0]      xs;
        logic [7:0]      cnt;
        logic [7:0]      ocr;
        logic [7:0]      ctl;
        logic [7:0]      cnt_rd;
        logic            up;
        logic            out;
        logic [2:0]      busy;
        logic [2:0][7:0] tmp;
        logic [2:0][1:0] edg;
        logic            ovf;
        logic            cmf;
        logic [1:0]      ovp;
        logic [1:0]      cmp;
        logic            armed;
        logic            pend;
        logic            wake;
    } atp_core_s;
    localparam atp_core_s CORE_RST = '{up: 1'b1, armed: 1'b1, default: '0};

endpackage

/* shared/atp_tick_if.sv */
`timescale 1ns/10ps
// carries the tick source and clock select to the prescaler and the tick back
interface atp_tick_if;
    logic       src_en;
    logic [2:0] sel;
    logic       tick;
    modport core  (output src_en, output sel, input tick);
    modport presc (input src_en, input sel, output tick);
endinterface

/* src/atp_prescaler.sv */
`timescale 1ns/10ps
module atp_prescaler #(
    parameter int DIV_W = 10
) (
    // clock and reset
    input  wire logic  i_clock,
    input  wire logic  i_rst_n,
    // tick source and select
    atp_tick_if.presc  tk
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
    } atp_presc_s;

    atp_presc_s s_q;
    atp_presc_s s_d;

    // ****************************************
    // divider chain
    // ****************************************
    // free-running so every divided tap shares one phase
    always_comb begin
        s_d = s_q;
        if (tk.src_en) begin
            s_d.div = s_q.div + 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // tick when all tap bits are ones; select 0 stops the timer
    assign tk.tick = tk.src_en && (tk.sel != 3'h0) &&
        ((s_q.div & atp_pkg::presc_mask(tk.sel)) == atp_pkg::presc_mask(tk.sel));

    a_div_tap_full: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        tk.tick |-> (s_q.div[2:0] == 3'h7) || (tk.sel == 3'h1))
        else $error("prescaled tick off its tap");

endmodule

/* src/atp_timer.sv */
`timescale 1ns/10ps
module atp_timer (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // crystal clock pin and source select
    input  wire logic       i_crystal_clock_pin,
    input  wire logic       i_async_clock_select,
    // processor writes
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_count_wr,
    input  wire logic       i_compare_wr,
    input  wire logic       i_control_wr,
    // flag clears and enables
    input  wire logic       i_overflow_flag_clr,
    input  wire logic       i_compare_flag_clr,
    input  wire logic       i_overflow_irq_enable,
    input  wire logic       i_compare_irq_enable,
    input  wire logic       i_sleep,
    input  wire logic       i_pin_dir_out,
    // register read-back
    output logic [7:0]      o_count_value,
    output logic [7:0]      o_compare_value,
    output logic [7:0]      o_timer_control,
    // async status
    output logic            o_count_update_busy,
    output logic            o_compare_update_busy,
    output logic            o_control_update_busy,
    // flags and wake
    output logic            o_overflow_flag,
    output logic            o_compare_match_flag,
    output logic            o_irq,
    output logic            o_wake,
    // compare output pin
    output logic            o_compare_output,
    output logic            o_compare_output_oe
);

    atp_pkg::atp_core_s s_q;
    atp_pkg::atp_core_s s_d;
    atp_tick_if         tk ();

    logic       xedge;
    logic       async_m;
    logic       tick;
    logic       phase;
    logic [1:0] com;
    logic       match;
    logic       cm_evt;
    logic       ov_evt;
    logic       irq_evt;
    logic       wake_now;
    logic       up_res;
    logic       dn_res;
    logic [2:0] wr;
    logic [2:0] xfer;

    // ****************************************
    // crystal edge and tick source
    // ****************************************
    // edge taken past the second flop so the first stays a pure synchroniser
    assign xedge    = s_q.xs[1] && !s_q.xs[2];
    assign async_m  = i_async_clock_select;
    assign tk.src_en = async_m ? xedge : 1'b1;
    assign tk.sel   = s_q.ctl[atp_pkg::CTL_CS_LSB +: 3];
    assign tick     = tk.tick;

    atp_prescaler #(
        .DIV_W (10)
    ) u_presc (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .tk      (tk)
    );

    // ****************************************
    // mode decode and compare
    // ****************************************
    assign phase  = {s_q.ctl[atp_pkg::CTL_WGM1], s_q.ctl[atp_pkg::CTL_WGM0]}
                    == atp_pkg::WGM_PHASE;
    assign com    = s_q.ctl[atp_pkg::CTL_COM_LSB +: 2];
    assign up_res = (com == atp_pkg::COM_SET_UP);
    assign dn_res = (com == atp_pkg::COM_CLR_UP);
    // pending count or compare write blocks the comparator
    assign match  = (s_q.cnt == s_q.ocr)
                    && !s_q.busy[atp_pkg::CH_CNT]
                    && !s_q.busy[atp_pkg::CH_OCR];
    assign cm_evt = tick && match;
    // phase mode overflows on arrival at zero, others on wrap
    assign ov_evt = tick && (phase ? (!s_q.up && s_q.cnt == atp_pkg::CNT_ONE)
                                   : (s_q.cnt == atp_pkg::CNT_MAX));
    assign irq_evt = (ov_evt && i_overflow_irq_enable)
                     || (cm_evt && i_compare_irq_enable);
    assign wake_now = s_q.pend && xedge;
    assign wr = {i_control_wr, i_compare_wr, i_count_wr};

    // ****************************************
    // transfer completion per channel
    // ****************************************
    // sync mode lands next cycle; async needs the second crystal edge
    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_xfer
            assign xfer[ch] = s_q.busy[ch] && !wr[ch] && (!async_m
                || (xedge && s_q.edg[ch] == atp_pkg::XFER_EDGES - 2'h1));
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.xs = {s_q.xs[1:0], i_crystal_clock_pin};
        s_d.wake = 1'b0;

        // temporaries; a new write restarts its own channel only
        for (int ch = 0; ch < 3; ch++) begin
            if (wr[ch]) begin
                s_d.busy[ch] = 1'b1;
                s_d.tmp[ch]  = i_wdata;
                s_d.edg[ch]  = 2'h0;
            end else if (xfer[ch]) begin
                s_d.busy[ch] = 1'b0;
            end else if (s_q.busy[ch] && xedge) begin
                s_d.edg[ch] = s_q.edg[ch] + 2'h1;
            end
        end

        // dual-slope count, one tick held at the top
        if (tick) begin
            if (phase) begin
                if (s_q.up) begin
                    if (s_q.cnt == atp_pkg::CNT_MAX) begin
                        s_d.cnt = atp_pkg::CNT_MAX - 8'h01;
                        s_d.up  = 1'b0;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end else begin
                    if (s_q.cnt == atp_pkg::CNT_BOTTOM) begin
                        s_d.cnt = atp_pkg::CNT_ONE;
                        s_d.up  = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt - 8'h01;
                    end
                end
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
                s_d.up  = 1'b1;
            end
        end

        // waveform on the tick itself, no resync to the cpu side
        if (tick && phase && com != atp_pkg::COM_OFF) begin
            if (s_q.ocr == atp_pkg::CNT_BOTTOM) begin
                s_d.out = up_res;
            end else if (s_q.ocr == atp_pkg::CNT_MAX) begin
                s_d.out = dn_res;
            end else if (s_q.cnt == atp_pkg::CNT_MAX) begin
                // top takes the up-match result, covering a missed match too
                s_d.out = up_res;
            end else if (match) begin
                s_d.out = s_q.up ? up_res : dn_res;
            end
        end

        // landing a temporary beats the tick on the same edge
        if (xfer[atp_pkg::CH_CNT]) begin
            s_d.cnt = s_q.tmp[atp_pkg::CH_CNT];
        end
        if (xfer[atp_pkg::CH_OCR]) begin
            s_d.ocr = s_q.tmp[atp_pkg::CH_OCR];
        end
        if (xfer[atp_pkg::CH_CTL]) begin
            s_d.ctl = s_q.tmp[atp_pkg::CH_CTL];
            s_d.ctl[atp_pkg::CTL_FORCE] = 1'b0;
        end

        // async flags ride a short pipe into the cpu side
        s_d.ovp = {s_q.ovp[0], ov_evt && async_m};
        s_d.cmp = {s_q.cmp[0], cm_evt && async_m};
        if (i_overflow_flag_clr) begin
            s_d.ovf = 1'b0;
        end
        if (i_compare_flag_clr) begin
            s_d.cmf = 1'b0;
        end
        // set after clear so a same-cycle event survives
        if (async_m ? s_q.ovp[1] : ov_evt) begin
            s_d.ovf = 1'b1;
        end
        if (async_m ? s_q.cmp[1] : cm_evt) begin
            s_d.cmf = 1'b1;
        end

        // wake request waits for the next timer clock cycle
        if (async_m && i_sleep && s_q.armed && irq_evt) begin
            s_d.pend = 1'b1;
        end
        if (wake_now) begin
            s_d.pend  = 1'b0;
            s_d.armed = 1'b0;
            s_d.wake  = 1'b1;
        end else if (!s_q.armed && xedge) begin
            // a full crystal cycle must pass before the next wake
            s_d.armed = 1'b1;
        end

        // read-back copy frozen while the cpu clock sleeps
        if (!i_sleep && (!async_m || xedge)) begin
            s_d.cnt_rd = s_q.cnt;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_q <= atp_pkg::CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_count_value         = s_q.cnt_rd;
    assign o_compare_value       = s_q.ocr;
    assign o_timer_control       = s_q.ctl;
    assign o_count_update_busy   = s_q.busy[atp_pkg::CH_CNT];
    assign o_compare_update_busy = s_q.busy[atp_pkg::CH_OCR];
    assign o_control_update_busy = s_q.busy[atp_pkg::CH_CTL];
    assign o_overflow_flag       = s_q.ovf;
    assign o_compare_match_flag  = s_q.cmf;
    assign o_irq = (s_q.ovf && i_overflow_irq_enable)
                   || (s_q.cmf && i_compare_irq_enable);
    assign o_wake                = s_q.wake;
    assign o_compare_output      = s_q.out;
    // disconnected action leaves the pin to the port
    assign o_compare_output_oe   = i_pin_dir_out && (com != atp_pkg::COM_OFF);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_top_reverse: assert property (
        tick && phase && s_q.up && s_q.cnt == atp_pkg::CNT_MAX && !xfer[0]
        |=> s_q.cnt == 8'hfe && !s_q.up)
        else $error("count did not turn at the top");

    a_bottom_turn: assert property (
        tick && phase && !s_q.up && s_q.cnt == atp_pkg::CNT_BOTTOM && !xfer[0]
        |=> s_q.cnt == 8'h01 && s_q.up)
        else $error("count did not turn at the bottom");

    a_sync_overflow: assert property (
        !async_m && ov_evt |=> o_overflow_flag)
        else $error("overflow flag missed in sync mode");

    a_async_flag_lag: assert property (
        async_m && ov_evt |-> ##3 o_overflow_flag)
        else $error("async overflow flag late");

    a_busy_after_wr: assert property (
        i_compare_wr |=> o_compare_update_busy)
        else $error("compare busy not set by write");

    a_busy_two_edges: assert property (
        async_m && o_count_update_busy && xedge && s_q.edg[0] == 2'h1
        && !i_count_wr |=> !o_count_update_busy && s_q.cnt == $past(s_q.tmp[0]))
        else $error("count transfer not after two edges");

    // a pending write must leave the waveform alone even on an equal count
    a_match_blocked: assert property (
        (o_count_update_busy || o_compare_update_busy) && tick && phase
        && s_q.cnt == s_q.ocr && s_q.cnt != atp_pkg::CNT_MAX
        && s_q.ocr != atp_pkg::CNT_BOTTOM && s_q.ocr != atp_pkg::CNT_MAX
        |=> $stable(o_compare_output))
        else $error("compare match while write pending");

    a_zero_low: assert property (
        tick && phase && com == atp_pkg::COM_CLR_UP
        && s_q.ocr == atp_pkg::CNT_BOTTOM |=> !o_compare_output)
        else $error("compare zero did not hold low");

    a_pin_gated: assert property (
        !i_pin_dir_out |-> !o_compare_output_oe)
        else $error("pin driven while direction is input");

    a_wake_on_edge: assert property (
        s_q.pend && xedge |=> o_wake ##1 !o_wake)
        else $error("wake not on the next timer edge");

    a_read_holds: assert property (
        async_m && !xedge |=> $stable(o_count_value))
        else $error("read-back changed between crystal edges");

    // tick source and stop checks
    a_stop_holds: assert property (
        tk.sel == 3'h0 && !xfer[atp_pkg::CH_CNT] |=> $stable(s_q.cnt))
        else $error("count moved while stopped");

    a_sync_tick: assert property (
        !async_m && tk.sel == 3'h1 |-> tick)
        else $error("sync tick missing");

    a_async_tick: assert property (
        async_m && !xedge |-> !tick)
        else $error("tick without a crystal edge");

    // waveform corner checks
    a_top_result: assert property (
        tick && phase && com == atp_pkg::COM_CLR_UP && s_q.cnt == atp_pkg::CNT_MAX
        && s_q.ocr != atp_pkg::CNT_BOTTOM && s_q.ocr != atp_pkg::CNT_MAX
        |=> !o_compare_output)
        else $error("top did not take the up result");

    a_full_high: assert property (
        tick && phase && com == atp_pkg::COM_CLR_UP
        && s_q.ocr == atp_pkg::CNT_MAX |=> o_compare_output)
        else $error("compare maximum did not hold high");

    // transfer and wake bookkeeping
    a_rearm_edge: assert property (
        !s_q.armed && xedge && !wake_now |=> s_q.armed)
        else $error("wake logic not rearmed");

    a_force_zero: assert property (
        !o_timer_control[atp_pkg::CTL_FORCE])
        else $error("force bit read back as one");

    a_sync_land: assert property (
        !async_m && o_compare_update_busy && !i_compare_wr |=> !o_compare_update_busy)
        else $error("sync compare transfer late");

    // covers for the main scenarios
    c_top_turn:  cover property (tick && phase && s_q.cnt == atp_pkg::CNT_MAX);
    c_wake:      cover property (o_wake);
    c_async_xfer: cover property (async_m && xfer[atp_pkg::CH_OCR]);
    c_pwm_flip:  cover property (phase && $rose(o_compare_output));
    c_overflow:  cover property (phase && ov_evt);

endmodule

/* test/tb_async_timer_phase_correct_pwm.sv */
`timescale 1ns/10ps
module tb_async_timer_phase_correct_pwm;
    // ****************************************
    // stimulus, observation and bookkeeping
    // ****************************************
    logic       i_clock;
    logic       i_rst_n;
    logic       i_crystal_clock_pin = 1'b0;
    logic       i_async_clock_select;
    logic [7:0] i_wdata;
    logic       i_count_wr, i_compare_wr, i_control_wr;
    logic       i_overflow_flag_clr, i_compare_flag_clr;
    logic       i_overflow_irq_enable, i_compare_irq_enable;
    logic       i_sleep, i_pin_dir_out;
    logic [7:0] o_count_value, o_compare_value, o_timer_control;
    logic       o_count_update_busy, o_compare_update_busy, o_control_update_busy;
    logic       o_overflow_flag, o_compare_match_flag, o_irq, o_wake;
    logic       o_compare_output, o_compare_output_oe;
    logic       xtal_run = 1'b0;
    logic [2:0] xdiv     = 3'h0;
    int         n_xedge  = 0;
    int         seed     = 57;
    int         n_fail   = 0;
    int         compares = 0;

    atp_timer u_atp_timer (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_crystal_clock_pin(i_crystal_clock_pin),
        .i_async_clock_select(i_async_clock_select), .i_wdata(i_wdata),
        .i_count_wr(i_count_wr), .i_compare_wr(i_compare_wr), .i_control_wr(i_control_wr),
        .i_overflow_flag_clr(i_overflow_flag_clr), .i_compare_flag_clr(i_compare_flag_clr),
        .i_overflow_irq_enable(i_overflow_irq_enable),
        .i_compare_irq_enable(i_compare_irq_enable), .i_sleep(i_sleep),
        .i_pin_dir_out(i_pin_dir_out), .o_count_value(o_count_value),
        .o_compare_value(o_compare_value), .o_timer_control(o_timer_control),
        .o_count_update_busy(o_count_update_busy),
        .o_compare_update_busy(o_compare_update_busy),
        .o_control_update_busy(o_control_update_busy), .o_overflow_flag(o_overflow_flag),
        .o_compare_match_flag(o_compare_match_flag), .o_irq(o_irq), .o_wake(o_wake),
        .o_compare_output(o_compare_output), .o_compare_output_oe(o_compare_output_oe));

    // 250 MHz system clock
    always #2 i_clock = ~i_clock;

    // crystal stand-in, ten system cycles a period, unrelated to the write strobes
    always @(posedge i_clock) begin
        if (xtal_run) begin
            xdiv <= (xdiv == 3'h4) ? 3'h0 : xdiv + 3'h1;
            if (xdiv == 3'h4) begin
                i_crystal_clock_pin <= ~i_crystal_clock_pin;
                if (!i_crystal_clock_pin) n_xedge <= n_xedge + 1;
            end
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one-cycle strobe; the next call waits an edge before raising again
    task automatic wr(input int ch, input logic [7:0] v);
        @(posedge i_clock);
        i_wdata      <= v;
        i_count_wr   <= (ch == atp_pkg::CH_CNT);
        i_compare_wr <= (ch == atp_pkg::CH_OCR);
        i_control_wr <= (ch == atp_pkg::CH_CTL);
        @(posedge i_clock);
        i_count_wr   <= 1'b0;
        i_compare_wr <= 1'b0;
        i_control_wr <= 1'b0;
    endtask

    task automatic wait_cnt(input logic [7:0] v, input int lim);
        int k;
        k = 0;
        while (o_count_value !== v && k < lim) begin
            @(posedge i_clock);
            #1;
            k++;
        end
        chk(16'(k < lim), 16'h1, "count never reached");
    endtask

    function automatic logic [7:0] ctl_byte(input logic [1:0] m, input logic [1:0] act,
                                            input logic [2:0] cs);
        return {1'b0, m[0], act, m[1], cs};
    endfunction

    // high cycles in one period: 2c ticks for clear-on-up, the rest when inverted
    function automatic logic [15:0] exp_high(input logic [7:0] c, input logic [1:0] act,
                                             input int div);
        int h;
        h = 2 * c;
        if (act == atp_pkg::COM_SET_UP) h = 510 - h;
        return 16'(h * div);
    endfunction

    task automatic pwm_run(input logic [7:0] c, input logic [1:0] act, input logic [2:0] cs,
                           input int div);
        int h;
        h = 0;
        wr(atp_pkg::CH_CTL, ctl_byte(atp_pkg::WGM_PHASE, act, cs));
        wr(atp_pkg::CH_OCR, c);
        i_pin_dir_out <= 1'($random(seed));
        repeat (520 * div) @(posedge i_clock);
        #1;
        chk(16'(o_compare_output_oe), 16'(i_pin_dir_out), "pin enable");
        repeat (510 * div) begin
            @(posedge i_clock);
            #1;
            if (o_compare_output === 1'b1) h++;
        end
        chk(16'(h), exp_high(c, act, div), "pwm high time");
    endtask

    // ****************************************
    // watchdog, sized well above the planned run
    // ****************************************
    initial begin
        repeat (80000) @(posedge i_clock);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [7:0] e, r;
        logic       up;
        int         k;
        logic [1:0] wm [3] = '{2'h0, 2'h2, 2'h3};
        logic [7:0] cv [8] = '{8'h00, 8'hff, 8'h01, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00};
        i_clock = 1'b0;
        i_rst_n = 1'b0;
        {i_async_clock_select, i_wdata, i_count_wr, i_compare_wr, i_control_wr} = '0;
        {i_overflow_flag_clr, i_compare_flag_clr, i_overflow_irq_enable} = '0;
        {i_compare_irq_enable, i_sleep, i_pin_dir_out} = '0;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        chk({o_count_value, o_timer_control}, 16'h0, "reset count/control");
        chk({o_compare_value, 3'h0, o_count_update_busy, o_compare_update_busy,
             o_control_update_busy, o_overflow_flag, o_compare_output}, 16'h0, "reset state");
        // sync write walk: busy one cycle after taking, value the cycle after
        wr(atp_pkg::CH_OCR, 8'h5a);
        #1;
        chk({o_compare_value, 7'h0, o_compare_update_busy}, 16'h0001, "busy set");
        @(posedge i_clock);
        #1;
        chk({o_compare_value, 7'h0, o_compare_update_busy}, 16'h5a00, "latched");
        // force bit reads back as zero
        wr(atp_pkg::CH_CTL, 8'he1);
        repeat (3) @(posedge i_clock);
        #1;
        chk(16'(o_timer_control), 16'h0061, "control read-back");
        // dual-slope sequence from bottom, one cycle held at the top
        wait_cnt(8'h00, 600);
        e = 8'h00;
        up = 1'b0;
        for (int i = 0; i < 1020; i++) begin
            if (up && e == 8'hff) begin up = 1'b0; e = 8'hfe; end
            else if (!up && e == 8'h00) begin up = 1'b1; e = 8'h01; end
            else e = up ? e + 8'h1 : e - 8'h1;
            @(posedge i_clock);
            #1;
            chk(16'(o_count_value), 16'(e), "dual-slope count");
        end
        // overflow flag only at bottom, and gating of the request
        wait_cnt(8'h80, 600);
        i_overflow_flag_clr <= 1'b1;
        @(posedge i_clock);
        i_overflow_flag_clr <= 1'b0;
        repeat (4) @(posedge i_clock);
        #1;
        chk(16'(o_overflow_flag), 16'h0, "flag away from bottom");
        wait_cnt(8'h00, 600);
        repeat (4) @(posedge i_clock);
        #1;
        chk(16'(o_overflow_flag), 16'h1, "flag at bottom");
        chk(16'(o_irq), 16'h0, "irq masked");
        i_overflow_irq_enable <= 1'b1;
        @(posedge i_clock);
        #1;
        chk(16'(o_irq), 16'h1, "irq enabled");
        i_overflow_irq_enable <= 1'b0;
        // compare flag: cleared, then set again where the count meets 0x5a
        i_compare_flag_clr <= 1'b1;
        @(posedge i_clock);
        i_compare_flag_clr <= 1'b0;
        #1;
        chk(16'(o_compare_match_flag), 16'h0, "compare flag cleared");
        wait_cnt(8'h5a, 600);
        #1;
        chk(16'(o_compare_match_flag), 16'h1, "compare flag at match");
        // other modes wrap straight from top to zero
        foreach (wm[m]) begin
            wr(atp_pkg::CH_CTL, ctl_byte(wm[m], 2'h0, 3'h1));
            wait_cnt(8'hfe, 600);
            @(posedge i_clock);
            #1;
            chk(16'(o_count_value), 16'h00ff, "single-slope top");
            @(posedge i_clock);
            #1;
            chk(16'(o_count_value), 16'h0000, "single-slope wrap");
        end
        // stopped clock select holds the count
        wr(atp_pkg::CH_CTL, ctl_byte(atp_pkg::WGM_PHASE, 2'h2, 3'h0));
        repeat (4) @(posedge i_clock);
        #1;
        r = o_count_value;
        chk(16'(o_compare_output_oe), 16'(i_pin_dir_out), "enable follows direction");
        repeat (20) @(posedge i_clock);
        #1;
        chk(16'(o_count_value), 16'(r), "stopped count");
        // extremes first, then random compare values, both polarities
        for (int i = 4; i < 8; i++) cv[i] = 8'($random(seed));
        foreach (cv[i]) pwm_run(cv[i], i[0] ? atp_pkg::COM_SET_UP : atp_pkg::COM_CLR_UP,
                                3'h1, 1);
        pwm_run(8'($random(seed)), atp_pkg::COM_CLR_UP, 3'h2, 8);
        // source switch with irqs off: select, rewrite, wait for the busy flags
        i_async_clock_select <= 1'b1;
        xtal_run <= 1'b1;
        wr(atp_pkg::CH_CTL, ctl_byte(atp_pkg::WGM_PHASE, 2'h2, 3'h1));
        wr(atp_pkg::CH_CNT, 8'h00);
        repeat (80) @(posedge i_clock);
        #1;
        chk(16'({o_count_update_busy, o_control_update_busy}), 16'h0, "switch");
        // write clear of a crystal rise so bench and design count edges alike
        @(posedge i_crystal_clock_pin);
        repeat (3) @(posedge i_clock);
        wr(atp_pkg::CH_OCR, 8'h33);
        k = n_xedge;
        repeat (2) @(posedge i_clock);
        #1;
        chk(16'(o_compare_update_busy), 16'h1, "async busy");
        while (o_compare_update_busy !== 1'b0 && n_xedge - k < 6) begin
            @(posedge i_clock);
            #1;
        end
        #1;
        chk(16'(n_xedge - k >= 2), 16'h1, "two crystal edges");
        chk(16'(o_compare_value), 16'h0033, "async latch");
        // sleep freezes read-back; wake from overflow
        i_overflow_flag_clr <= 1'b1;
        i_overflow_irq_enable <= 1'b1;
        i_sleep <= 1'b1;
        @(posedge i_clock);
        i_overflow_flag_clr <= 1'b0;
        @(posedge i_clock);
        #1;
        r = o_count_value;
        k = 0;
        while (o_wake !== 1'b1 && k < 6000) begin
            @(posedge i_clock);
            #1;
            k++;
        end
        chk(16'(k < 6000), 16'h1, "wake pulse");
        chk(16'(o_count_value), 16'(r), "frozen during sleep");
        i_sleep <= 1'b0;
        repeat (40) @(posedge i_clock);
        #1;
        chk(16'(o_count_value != r), 16'h1, "count advanced after wake");
        wrap_up();
    end
endmodule
